// file: include/irq_consts.svh
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define GLOBAL_IRQ_ENABLE_OFS   8'h20
`define ENDPOINT_IRQ_ENABLE_OFS 8'h21
`define PENDING_LO_OFS          8'h22
`define PENDING_HI_OFS          8'h23

// ---------------------------------------------------------------
// Reset values and writable bits
// ---------------------------------------------------------------
`define GLOBAL_IRQ_ENABLE_RST   8'h00
`define ENDPOINT_IRQ_ENABLE_RST 8'h00
`define GLOBAL_IRQ_ENABLE_MASK  8'h7F
`define ENDPOINT_IRQ_ENABLE_MASK 8'h1F

// ---------------------------------------------------------------
// Global enable field positions
// ---------------------------------------------------------------
`define GEN_BUS_RESET_BIT 0
`define GEN_FAST_TMR_BIT  1
`define GEN_SLOW_TMR_BIT  2
`define GEN_HUB_BIT       3
`define GEN_ANALOG_BIT    4
`define GEN_GPIO_BIT      5
`define GEN_SERIAL_BIT    6

// ---------------------------------------------------------------
// Pending high register field positions
// ---------------------------------------------------------------
`define PHI_GIE_BIT   2
`define PHI_SENSE_BIT 7

// ---------------------------------------------------------------
// Sources, vectors, pins
// ---------------------------------------------------------------
`define NUM_SOURCES  12
`define NUM_ENDPOINTS 5
`define GPIO_PINS    8
`define RESET_FETCH_ADDR 16'h0000

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 5
`define FAST_TIMER_NS 128000
`define SLOW_TIMER_NS 1024000

`endif

// file: include/irq_pkg.sv
`default_nettype none

package irq_pkg;
	typedef enum logic [1:0] {
		SVC_IDLE,
		SVC_CLEAR,
		SVC_CALL
	} svc_state_e;

	typedef logic [3:0]  vec_num_t;
	typedef logic [11:0] src_vec_t;
	typedef logic [15:0] prog_addr_t;
endpackage

`default_nettype wire

// file: verilog/pending_flag.sv
`default_nettype none

module pending_flag (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// Event and service
	input  wire logic set_evt,
	input  wire logic clr,
	// State
	output logic      pend
);
	// A new event in the clear cycle wins so it is never lost
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pend <= 1'b0;
		end else if (set_evt) begin
			pend <= 1'b1;
		end else if (clr) begin
			pend <= 1'b0;
		end
	end
endmodule

`default_nettype wire

// file: verilog/timer_tick.sv
`default_nettype none

module timer_tick #(
	parameter int PERIOD = 16
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// Periodic pulse
	output logic      tick
);
	localparam int CW = $clog2(PERIOD + 1);

	logic [CW-1:0] cnt_r;
	logic          wrap;

	assign wrap = (cnt_r == CW'(PERIOD - 1));

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			tick  <= 1'b0;
		end else begin
			cnt_r <= wrap ? '0 : cnt_r + CW'(1);
			tick  <= wrap;
		end
	end
endmodule

`default_nettype wire

// file: verilog/usb_mcu_interrupt_controller.sv
// Local design decision: the strobed register port.

`include "irq_consts.svh"

`default_nettype none

module usb_mcu_interrupt_controller #(
	parameter int FAST_TICK_CYCLES = `FAST_TIMER_NS / `CLK_PERIOD_NS,
	parameter int SLOW_TICK_CYCLES = `SLOW_TIMER_NS / `CLK_PERIOD_NS
) (
	// Clock and reset
	input  wire logic                         clk_sys,
	input  wire logic                         rst_n,
	// Register port
	input  wire logic [7:0]                   reg_addr,
	input  wire logic [7:0]                   reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [7:0]                   reg_rdata,
	// Pins from outside the clock domain
	input  wire logic                         upstream_se0,
	input  wire logic [`GPIO_PINS-1:0]        gpio_pin_in,
	// Source event pulses and the parallel host port select
	input  wire logic [`NUM_ENDPOINTS-1:0]    ep_evt,
	input  wire logic                         hub_evt,
	input  wire logic                         analog_evt,
	input  wire logic                         parallel_host_port_evt,
	input  wire logic                         serial_evt,
	input  wire logic                         parallel_host_port_en,
	// CPU core
	input  wire logic                         cpu_instr_done,
	input  wire logic                         irq_ack,
	input  wire logic                         disable_irq_instr,
	input  wire logic                         enable_irq_instr,
	input  wire logic                         return_from_irq_instr,
	output logic                              irq_req,
	output logic      [3:0]                   irq_vec_num,
	output logic                              call_req,
	output logic      [15:0]                  call_addr,
	output logic                              global_irq_flag,
	output logic                              irq_pending_sense
);

	// ---------------------------------------------------------------
	// Register port
	// ---------------------------------------------------------------
	logic [7:0]  glob_en_r;
	logic [7:0]  ep_en_r;
	logic [7:0]  rdata_nxt;
	logic        wr_glob;
	logic        wr_ep;
	logic        gie_r;
	irq_pkg::src_vec_t pending_q;

	assign wr_glob = reg_wr && (reg_addr == `GLOBAL_IRQ_ENABLE_OFS);
	assign wr_ep   = reg_wr && (reg_addr == `ENDPOINT_IRQ_ENABLE_OFS);

	// Reserved bits and unmapped offsets read as zero
	assign rdata_nxt =
		(reg_addr == `GLOBAL_IRQ_ENABLE_OFS)   ? glob_en_r :
		(reg_addr == `ENDPOINT_IRQ_ENABLE_OFS) ? ep_en_r :
		(reg_addr == `PENDING_LO_OFS)          ? pending_q[7:0] :
		(reg_addr == `PENDING_HI_OFS)          ?
			{irq_pending_sense, 2'h0, 1'b0, 1'b0, gie_r, 2'h0} | {4'h0, pending_q[11:8]} :
		8'h00;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			glob_en_r <= `GLOBAL_IRQ_ENABLE_RST;
			ep_en_r   <= `ENDPOINT_IRQ_ENABLE_RST;
			reg_rdata <= 8'h00;
		end else begin
			if (wr_glob) begin
				glob_en_r <= reg_wdata & `GLOBAL_IRQ_ENABLE_MASK;
			end
			if (wr_ep) begin
				ep_en_r <= reg_wdata & `ENDPOINT_IRQ_ENABLE_MASK;
			end
			// Data stand only in the cycle after the read strobe
			reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Bit 8 carries SE0, bits 7..0 the GPIO pins. A change counts once
	// the second and third stages agree, which rejects a single-cycle
	// metastable glitch at the cost of one more cycle of latency.
	localparam int PIN_W = `GPIO_PINS + 1;

	logic [PIN_W-1:0] pin_s1_r;
	logic [PIN_W-1:0] pin_s2_r;
	logic [PIN_W-1:0] pin_s3_r;
	logic [PIN_W-1:0] pin_stable_r;
	logic [1:0]       pin_fill_r;
	logic [PIN_W-1:0] pin_agree;
	logic [PIN_W-1:0] pin_change;
	logic             se0_released;
	logic             gpio_edge;

	assign pin_agree    = ~(pin_s2_r ^ pin_s3_r);
	assign pin_change   = pin_agree & (pin_s3_r ^ pin_stable_r) & {PIN_W{&pin_fill_r}};
	assign se0_released = pin_change[PIN_W-1] && !pin_s3_r[PIN_W-1];
	assign gpio_edge    = |pin_change[`GPIO_PINS-1:0];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_r     <= '0;
			pin_s2_r     <= '0;
			pin_s3_r     <= '0;
			pin_stable_r <= '0;
			pin_fill_r   <= 2'h0;
		end else begin
			pin_s1_r <= {upstream_se0, gpio_pin_in};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			// Stable tracks stage two until the chain fills: no false edge after reset
			if (!(&pin_fill_r)) begin
				pin_fill_r   <= pin_fill_r + 2'h1;
				pin_stable_r <= pin_s2_r;
			end else begin
				pin_stable_r <= (pin_stable_r & ~pin_agree) | (pin_s3_r & pin_agree);
			end
		end
	end

	// ---------------------------------------------------------------
	// Timers
	// ---------------------------------------------------------------
	logic fast_tick;
	logic slow_tick;

	timer_tick #(
		.PERIOD (FAST_TICK_CYCLES)
	) u_fast_timer (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.tick    (fast_tick)
	);

	timer_tick #(
		.PERIOD (SLOW_TICK_CYCLES)
	) u_slow_timer (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.tick    (slow_tick)
	);

	// ---------------------------------------------------------------
	// Source events and pending flip-flops
	// ---------------------------------------------------------------
	irq_pkg::src_vec_t set_evt;
	irq_pkg::src_vec_t clr_mask;
	irq_pkg::src_vec_t en_vec;
	irq_pkg::src_vec_t req_vec;
	logic              pin_port_evt;

	// Parallel host port owns the pin vector and blocks the GPIO pin edges; an SE0 release still sets bus reset
	assign pin_port_evt = parallel_host_port_en ? parallel_host_port_evt : gpio_edge;

	// Index i serves vector i + 1
	assign set_evt = {serial_evt, pin_port_evt, analog_evt, hub_evt,
		ep_evt, slow_tick, fast_tick, se0_released};

	assign en_vec = {glob_en_r[`GEN_SERIAL_BIT], glob_en_r[`GEN_GPIO_BIT],
		glob_en_r[`GEN_ANALOG_BIT], glob_en_r[`GEN_HUB_BIT],
		ep_en_r[`NUM_ENDPOINTS-1:0], glob_en_r[`GEN_SLOW_TMR_BIT],
		glob_en_r[`GEN_FAST_TMR_BIT], glob_en_r[`GEN_BUS_RESET_BIT]};

	assign req_vec = pending_q & en_vec;

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_SOURCES; gi++) begin : g_pend
			pending_flag u_pend (
				.clk_sys (clk_sys),
				.rst_n   (rst_n),
				.set_evt (set_evt[gi]),
				.clr     (clr_mask[gi]),
				.pend    (pending_q[gi])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Priority encoder
	// ---------------------------------------------------------------
	irq_pkg::vec_num_t win_num;

	always_comb begin
		win_num = 4'h0;
		// Walk downward so the lowest index, the highest priority, wins
		for (int i = `NUM_SOURCES - 1; i >= 0; i--) begin
			if (req_vec[i]) begin
				win_num = 4'(i + 1);
			end
		end
	end

	assign irq_req           = gie_r && (|req_vec);
	assign irq_vec_num       = win_num;
	assign global_irq_flag   = gie_r;
	assign irq_pending_sense = |pending_q;

	// ---------------------------------------------------------------
	// Service sequence
	// ---------------------------------------------------------------
	irq_pkg::svc_state_e state_r;
	irq_pkg::svc_state_e state_nxt;
	irq_pkg::vec_num_t   vec_r;
	logic                take;
	logic                boot_r;

	// Only at an instruction boundary, so no instruction is split
	assign take = (state_r == irq_pkg::SVC_IDLE) && irq_ack && irq_req
		&& cpu_instr_done;

	always_comb begin
		clr_mask = '0;
		if (state_r == irq_pkg::SVC_CLEAR) begin
			clr_mask[vec_r - 4'h1] = 1'b1;
		end
	end

	always_comb begin
		case (state_r)
			irq_pkg::SVC_IDLE:  state_nxt = take ? irq_pkg::SVC_CLEAR : irq_pkg::SVC_IDLE;
			irq_pkg::SVC_CLEAR: state_nxt = irq_pkg::SVC_CALL;
			irq_pkg::SVC_CALL:  state_nxt = irq_pkg::SVC_IDLE;
			default:            state_nxt = irq_pkg::SVC_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= irq_pkg::SVC_IDLE;
			vec_r   <= 4'h0;
		end else begin
			state_r <= state_nxt;
			if (take) begin
				vec_r <= win_num;
			end
		end
	end

	// Service always beats a coinciding enable, so the routine starts masked
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gie_r <= 1'b0;
		end else if (take) begin
			gie_r <= 1'b0;
		end else if (disable_irq_instr) begin
			gie_r <= 1'b0;
		end else if (enable_irq_instr || return_from_irq_instr) begin
			gie_r <= 1'b1;
		end
	end

	// The CPU pushes program counter, carry and zero on call_req and
	// nothing else; the stack depth alone bounds nesting.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			boot_r    <= 1'b1;
			call_req  <= 1'b0;
			call_addr <= `RESET_FETCH_ADDR;
		end else begin
			boot_r <= 1'b0;
			if (boot_r) begin
				call_req  <= 1'b1;
				call_addr <= `RESET_FETCH_ADDR;
			end else if (state_r == irq_pkg::SVC_CLEAR) begin
				call_req  <= 1'b1;
				call_addr <= {11'h000, vec_r, 1'b0};
			end else begin
				call_req  <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	a_take_clears_gie: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		take |=> !gie_r ##1 (state_r == irq_pkg::SVC_CALL))
		else $error("global flag not cleared on service");

	a_serviced_cleared: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(state_r == irq_pkg::SVC_CLEAR) && !set_evt[vec_r - 4'h1]
		|=> !pending_q[$past(vec_r) - 4'h1])
		else $error("serviced pending bit not cleared");

	a_pending_holds: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> (($past(pending_q) & ~$past(clr_mask)) & ~pending_q) == 12'h000)
		else $error("pending bit dropped without service");

	a_event_sets: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(set_evt != 12'h000) |=> ((pending_q & $past(set_evt)) == $past(set_evt)))
		else $error("event lost");

	a_req_gated: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		irq_req |-> gie_r && irq_vec_num != 4'h0 && ((req_vec & ((12'h001 << irq_vec_num)
			- 12'h001)) == (12'h001 << (irq_vec_num - 4'h1))))
		else $error("request without enabled pending source");

	a_top_priority: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(pending_q[0] && glob_en_r[`GEN_BUS_RESET_BIT]) |-> (irq_vec_num == 4'h1))
		else $error("bus reset did not win priority");

	a_call_vector: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		take |-> ##2 call_req && (call_addr == {11'h000, $past(win_num, 2), 1'b0}))
		else $error("wrong call address");

	a_boundary_only: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(state_r == irq_pkg::SVC_IDLE) ##1 (state_r == irq_pkg::SVC_CLEAR)
		|-> $past(cpu_instr_done))
		else $error("service began mid-instruction");

	a_flag_only: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		(enable_irq_instr && !take && !disable_irq_instr && !wr_glob && !wr_ep)
		|=> gie_r && $stable(glob_en_r) && $stable(ep_en_r))
		else $error("enable instruction misbehaved");

	a_reset_fetch: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		rst_n && boot_r |=> call_req && (call_addr == 16'h0000))
		else $error("first fetch not at zero");

endmodule

`default_nettype wire

// file: verification/cpu_core_model.sv
`default_nettype none

module cpu_core_model (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// Bench controls
	input  wire logic       ack_on,
	input  wire logic       slow,
	// Controller side
	input  wire logic       irq_req,
	input  wire logic       call_req,
	output logic            cpu_instr_done,
	output logic            irq_ack,
	output logic            return_from_irq_instr,
	output logic      [3:0] depth
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] phase_r;
	logic [2:0] svc_r;
	logic       busy_r;

	// Depth stands in for the pushed return address and flags; the reset
	// fetch is not a service call, so only calls taken while busy count
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= 2'h0;
			svc_r <= 3'h0;
			busy_r <= 1'b0;
			depth <= 4'h0;
			cpu_instr_done <= 1'b0;
			irq_ack <= 1'b0;
			return_from_irq_instr <= 1'b0;
		end else begin
			phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
			cpu_instr_done <= !slow || (phase_r == 2'h1);
			irq_ack <= ack_on && irq_req && !busy_r;
			return_from_irq_instr <= 1'b0;
			if (irq_ack && irq_req && cpu_instr_done) begin
				busy_r <= 1'b1;
			end
			if (call_req && busy_r) begin
				depth <= depth + 4'h1;
				svc_r <= 3'h4;
			end else if (svc_r == 3'h1) begin
				return_from_irq_instr <= 1'b1;
				depth <= depth - 4'h1;
				busy_r <= 1'b0;
				svc_r <= 3'h0;
			end else if (svc_r != 3'h0) begin
				svc_r <= svc_r - 3'h1;
			end
		end
	end
endmodule

`default_nettype wire

// file: verification/usb_mcu_interrupt_controller_bench.sv
`default_nettype none

module usb_mcu_interrupt_controller_bench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int FAST = 8;
	localparam int SLOW = 20;

	logic        clk_sys = 1'b0;
	logic        rst_n, reg_wr, reg_rd, upstream_se0, hub_evt, analog_evt;
	logic        parallel_host_port_evt, serial_evt, parallel_host_port_en;
	logic        disable_irq_instr, enable_irq_instr, cpu_instr_done, irq_ack;
	logic        return_from_irq_instr, irq_req, call_req, global_irq_flag;
	logic        irq_pending_sense, ack_on, slow;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, gpio_pin_in, lfsr;
	logic [4:0]  ep_evt;
	logic [3:0]  irq_vec_num, depth;
	logic [15:0] call_addr;
	logic [15:0] calls[$];
	int          failures, n_tests;
	int          exp_v[10] = '{1, 4, 5, 6, 7, 8, 9, 10, 11, 12};

	always #2.5 clk_sys = ~clk_sys;

	usb_mcu_interrupt_controller #(.FAST_TICK_CYCLES(FAST), .SLOW_TICK_CYCLES(SLOW)) DUT (
		.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.upstream_se0(upstream_se0), .gpio_pin_in(gpio_pin_in), .ep_evt(ep_evt),
		.hub_evt(hub_evt), .analog_evt(analog_evt),
		.parallel_host_port_evt(parallel_host_port_evt), .serial_evt(serial_evt),
		.parallel_host_port_en(parallel_host_port_en), .cpu_instr_done(cpu_instr_done),
		.irq_ack(irq_ack), .disable_irq_instr(disable_irq_instr),
		.enable_irq_instr(enable_irq_instr), .return_from_irq_instr(return_from_irq_instr),
		.irq_req(irq_req), .irq_vec_num(irq_vec_num), .call_req(call_req),
		.call_addr(call_addr), .global_irq_flag(global_irq_flag),
		.irq_pending_sense(irq_pending_sense));

	cpu_core_model cpu (
		.clk_sys(clk_sys), .rst_n(rst_n), .ack_on(ack_on), .slow(slow), .irq_req(irq_req),
		.call_req(call_req), .cpu_instr_done(cpu_instr_done), .irq_ack(irq_ack),
		.return_from_irq_instr(return_from_irq_instr), .depth(depth));

	// ---------------------------------------------------------------
	// Expectations and bus tasks
	// ---------------------------------------------------------------
	function automatic logic [15:0] vec_addr(input int n);
		return 16'(2 * n);
	endfunction

	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 check("read data", {8'h00, exp & m}, {8'h00, reg_rdata & m});
	endtask

	task automatic pulse_src(input logic [4:0] ep, input logic [3:0] oth);
		@(posedge clk_sys);
		ep_evt <= ep;
		{hub_evt, analog_evt, parallel_host_port_evt, serial_evt} <= oth;
		@(posedge clk_sys);
		ep_evt <= 5'h00;
		{hub_evt, analog_evt, parallel_host_port_evt, serial_evt} <= 4'h0;
	endtask

	task automatic wait_calls(input int n);
		int k;
		k = 0;
		while (calls.size() < n && k < 600) begin
			@(posedge clk_sys);
			k++;
		end
		check("call count", 16'(n), 16'(calls.size()));
	endtask

	task automatic tally_and_finish();
		$display("Comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Every vector call must find the global flag already cleared
	always @(posedge clk_sys) begin
		if (rst_n === 1'b1 && call_req === 1'b1) begin
			calls.push_back(call_addr);
			check("flag at call", 16'h0000, {15'h0, global_irq_flag});
		end
	end

	initial begin
		#100000;
		failures++;
		tally_and_finish();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{rst_n, reg_wr, reg_rd, upstream_se0, hub_evt, analog_evt} = 6'h00;
		{parallel_host_port_evt, serial_evt, parallel_host_port_en} = 3'h0;
		{disable_irq_instr, enable_irq_instr, slow} = 3'h0;
		{reg_addr, reg_wdata, gpio_pin_in, ep_evt} = 29'h0;
		ack_on = 1'b1;
		lfsr = 8'h2F;
		failures = 0;
		n_tests = 0;
		idle(2);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		#1 check("reset fetch", 16'h0001, {15'h0, call_req});
		check("reset address", 16'h0000, call_addr);
		rd(8'h20, 8'h00, 8'hFF);
		rd(8'h21, 8'h00, 8'hFF);
		for (int i = 0; i < 6; i++) begin
			lfsr = lfsr_next(lfsr);
			wr(8'h20, lfsr);
			rd(8'h20, lfsr & 8'h7F, 8'hFF);
			lfsr = lfsr_next(lfsr);
			wr(8'h21, lfsr);
			rd(8'h21, lfsr & 8'h1F, 8'hFF);
		end
		wr(8'h20, 8'h00);
		wr(8'h21, 8'h00);
		rd(8'h40, 8'h00, 8'hFF);
		// Pin edges are swallowed while the parallel port owns the vector
		parallel_host_port_en <= 1'b1;
		gpio_pin_in <= 8'h5A;
		idle(8);
		rd(8'h23, 8'h00, 8'h04);
		pulse_src(5'h1F, 4'hF);
		upstream_se0 <= 1'b1;
		idle(3);
		upstream_se0 <= 1'b0;
		parallel_host_port_en <= 1'b0;
		idle(10);
		check("request while masked", 16'h0000, {15'h0, irq_req});
		check("vector while masked", 16'h0000, {12'h0, irq_vec_num});
		check("pending sense", 16'h0001, {15'h0, irq_pending_sense});
		rd(8'h22, 8'hF9, 8'hF9);
		rd(8'h23, 8'h0F, 8'h0F);
		wr(8'h20, 8'h79);
		wr(8'h21, 8'h1F);
		@(posedge clk_sys);
		disable_irq_instr <= 1'b1;
		@(posedge clk_sys);
		disable_irq_instr <= 1'b0;
		rd(8'h20, 8'h79, 8'hFF);
		check("vector number", 16'h0001, {12'h0, irq_vec_num});
		rd(8'h22, 8'hF9, 8'hF9);
		calls.delete();
		enable_irq_instr <= 1'b1;
		@(posedge clk_sys);
		enable_irq_instr <= 1'b0;
		wait_calls(10);
		foreach (exp_v[i]) check("vector order", vec_addr(exp_v[i]), calls[i]);
		idle(8);
		rd(8'h22, 8'h00, 8'hF9);
		rd(8'h23, 8'h00, 8'h0B);
		check("flag after return", 16'h0001, {15'h0, global_irq_flag});
		check("stack depth", 16'h0000, {12'h0, depth});
		// Rising edges, then falling edges, each raise the pin vector
		wr(8'h20, 8'h20);
		calls.delete();
		gpio_pin_in <= 8'hFF;
		wait_calls(1);
		check("rising edge vector", 16'h0016, calls[0]);
		idle(8);
		gpio_pin_in <= 8'h00;
		wait_calls(2);
		check("falling edge vector", 16'h0016, calls[1]);
		// Timers with the core finishing instructions only now and then
		slow <= 1'b1;
		wr(8'h20, 8'h02);
		idle(12);
		calls.delete();
		wait_calls(2);
		check("fast timer", vec_addr(2), calls[1]);
		wr(8'h20, 8'h04);
		idle(12);
		calls.delete();
		wait_calls(2);
		check("slow timer", vec_addr(3), calls[1]);
		idle(8);
		@(posedge clk_sys);
		disable_irq_instr <= 1'b1;
		@(posedge clk_sys);
		disable_irq_instr <= 1'b0;
		idle(SLOW + 4);
		check("flag after disable", 16'h0000, {15'h0, global_irq_flag});
		check("request after disable", 16'h0000, {15'h0, irq_req});
		rst_n <= 1'b0;
		idle(2);
		rst_n <= 1'b1;
		rd(8'h20, 8'h00, 8'hFF);
		rd(8'h21, 8'h00, 8'hFF);
		tally_and_finish();
	end
endmodule

`default_nettype wire
